// ---- hdl/dmpc_map.svh ----
// Register offsets, field positions, reset values and counts of the mute and powerdown control.
`ifndef DMPC_MAP_SVH
`define DMPC_MAP_SVH

//------------------------------------------------------------
// Register addresses (seven-bit control word address)
//------------------------------------------------------------
`define DMPC_ADDR_CHANNEL_CONTROL 7'h02
`define DMPC_ADDR_MUTE_CHANNEL_SELECT_A     7'h09
`define DMPC_ADDR_POWERDOWN       7'h0A
`define DMPC_ADDR_PIN_CONTROL     7'h0C

//------------------------------------------------------------
// Field positions
//------------------------------------------------------------
`define DMPC_BIT_GLOBAL_MUTE      0
`define DMPC_BIT_GLOBAL_CHANNEL_SELECT_A    1
`define DMPC_BIT_GLOBAL_POWERDOWN 2
`define DMPC_BIT_INF_ZERO         4
`define DMPC_CHMUTE_LSB           3
`define DMPC_CHANNEL_SELECT_A_LSB           6
`define DMPC_PAIRDIS_LSB          1
`define DMPC_ZFSEL_LSB            0
`define DMPC_BIT_PIN_DECODE_DIS   6

//------------------------------------------------------------
// Reset values and counts
//------------------------------------------------------------
`define DMPC_REG_RESET            9'h000
`define DMPC_ZERO_RUN             11'h400
`define DMPC_RAMP_SHIFT           6
`define DMPC_GAIN_FULL            16'hFFFF
`define DMPC_FRAME_BITS           5'h10

`endif

// ---- hdl/dmpc_pkg.sv ----
// Types shared by the mute and powerdown control.
package dmpc_pkg;
	typedef logic [6:0]  dmpc_addr_type;
	typedef logic [8:0]  dmpc_word_type;
	typedef logic [15:0] dmpc_gain_type;
	typedef logic [10:0] dmpc_count_type;
endpackage : dmpc_pkg

// ---- hdl/dmpc_top.sv ----
// Mute, automute, de-emphasis and powerdown control of a six-channel DAC.
//
// Behaviour
// - Per-pair mute field bits 5:3 mutes pairs.
// - Mute field acts right after serial write.
// - Global mute bit mutes all three pairs.
// - High mute pin mutes decoded pairs.
// - Low mute pin blocks automute; bits still mute.
// - Decode on: select picks all, pair1/2/3.
// - Decode off: high pin mutes all pairs.
// - Count zero samples; flag after 1024.
// - Undriven pin shows selected zero flags.
// - Own high pin level feeds mute decode.
// - Infinite-zero bit enables analogue mute of pairs.
// - Analogue mute only in software mode.
// - De-emphasis field bits 8:6 selects pairs.
// - Global de-emphasis bit applies to all pairs.
// - Global powerdown overrides per-pair disables.
// - Powerdown clears history, keeps registers.
// - Leaving powerdown reinitialises interpolation filters.
// - Pair disable field bits 3:1 powers pairs down.
// - Soft mute decays, 64-sample constant; release immediate.
`include "dmpc_map.svh"

module dmpc_top (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        mode_pin,
	input  wire logic        ctrl_latch,
	input  wire logic        ctrl_clk,
	input  wire logic        ctrl_data,
	input  wire logic        sample_valid,
	input  wire logic [23:0] din1_sample,
	input  wire logic [23:0] din2_sample,
	input  wire logic [23:0] din3_sample,
	input  wire logic        mute_pin_in,
	output logic             mute_pin_out,
	output logic             mute_pin_oe,
	output logic [2:0]       soft_mute,
	output logic [15:0]      pair1_gain,
	output logic [15:0]      pair2_gain,
	output logic [15:0]      pair3_gain,
	output logic [2:0]       zero_run_flags,
	output logic [2:0]       analog_mute,
	output logic [2:0]       channel_select_a_en,
	output logic [2:0]       pair_powered_down,
	output logic             history_clear,
	output logic             filter_reinit
);

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	// Pairs reached by a select code: zero means every pair.
	function automatic logic [2:0] sel_mask(input logic [1:0] sel);
		logic [2:0] m;
		m = 3'h7;
		if (sel == 2'h1) m = 3'h1;
		else if (sel == 2'h2) m = 3'h2;
		else if (sel == 2'h3) m = 3'h4;
		return m;
	endfunction : sel_mask

	function automatic dmpc_pkg::dmpc_gain_type decay(input dmpc_pkg::dmpc_gain_type g);
		return g - (g >> `DMPC_RAMP_SHIFT);
	endfunction : decay

	//------------------------------------------------------------
	// Serial control port
	//------------------------------------------------------------
	// The port pins are sampled on clk, so the serial clock must be well below clk/2.
	logic                    ctrl_clk_prev_reg;
	logic                    ctrl_latch_prev_reg;
	logic [15:0]             shift_reg;
	dmpc_pkg::dmpc_word_type chan_ctrl_reg;
	dmpc_pkg::dmpc_word_type mute_channel_select_a_reg;
	dmpc_pkg::dmpc_word_type power_ctrl_reg;
	dmpc_pkg::dmpc_word_type pin_ctrl_reg;
	logic                    write_strobe;
	dmpc_pkg::dmpc_addr_type write_addr;
	logic                    sw_mode;

	assign sw_mode      = ~mode_pin;
	assign write_strobe = ctrl_latch & ~ctrl_latch_prev_reg & sw_mode;
	assign write_addr   = shift_reg[15:9];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_clk_prev_reg   <= 1'b0;
			ctrl_latch_prev_reg <= 1'b0;
			shift_reg           <= 16'h0000;
		end else begin
			ctrl_clk_prev_reg   <= ctrl_clk;
			ctrl_latch_prev_reg <= ctrl_latch;
			if (ctrl_clk && !ctrl_clk_prev_reg)
				shift_reg <= {shift_reg[14:0], ctrl_data};
		end
	end

	// Registers keep their contents through powerdown; only reset clears them.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_ctrl_reg   <= `DMPC_REG_RESET;
			mute_channel_select_a_reg <= `DMPC_REG_RESET;
			power_ctrl_reg  <= `DMPC_REG_RESET;
			pin_ctrl_reg    <= `DMPC_REG_RESET;
		end else if (write_strobe) begin
			if (write_addr == `DMPC_ADDR_CHANNEL_CONTROL)
				chan_ctrl_reg <= shift_reg[8:0];
			else if (write_addr == `DMPC_ADDR_MUTE_CHANNEL_SELECT_A)
				mute_channel_select_a_reg <= shift_reg[8:0];
			else if (write_addr == `DMPC_ADDR_POWERDOWN)
				power_ctrl_reg <= shift_reg[8:0];
			else if (write_addr == `DMPC_ADDR_PIN_CONTROL)
				pin_ctrl_reg <= shift_reg[8:0];
		end
	end

	//------------------------------------------------------------
	// Field decode
	//------------------------------------------------------------
	logic [2:0] channel_mute_select;
	logic [2:0] channel_select_a;
	logic [2:0] pair_disable;
	logic [1:0] zero_flag_select;
	logic       global_mute;
	logic       global_channel_select_a;
	logic       global_powerdown;
	logic       infinite_zero_analog_mute_en;
	logic       pin_decode_disable;

	assign channel_mute_select = mute_channel_select_a_reg[`DMPC_CHMUTE_LSB +: 3];
	assign channel_select_a    = mute_channel_select_a_reg[`DMPC_CHANNEL_SELECT_A_LSB +: 3];
	assign pair_disable        = power_ctrl_reg[`DMPC_PAIRDIS_LSB +: 3];
	assign zero_flag_select    = pin_ctrl_reg[`DMPC_ZFSEL_LSB +: 2];
	assign pin_decode_disable  = pin_ctrl_reg[`DMPC_BIT_PIN_DECODE_DIS];
	assign global_mute         = chan_ctrl_reg[`DMPC_BIT_GLOBAL_MUTE];
	assign global_channel_select_a       = chan_ctrl_reg[`DMPC_BIT_GLOBAL_CHANNEL_SELECT_A];
	assign global_powerdown    = chan_ctrl_reg[`DMPC_BIT_GLOBAL_POWERDOWN];
	assign infinite_zero_analog_mute_en = chan_ctrl_reg[`DMPC_BIT_INF_ZERO];

	//------------------------------------------------------------
	// Zero-run counters
	//------------------------------------------------------------
	logic [23:0]              din_word [3];
	dmpc_pkg::dmpc_count_type zero_cnt_reg [3];
	logic [2:0]               zf;

	assign din_word[0] = din1_sample;
	assign din_word[1] = din2_sample;
	assign din_word[2] = din3_sample;

	for (genvar i = 0; i < 3; i++) begin : g_zero
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn)
				zero_cnt_reg[i] <= 11'h000;
			else if (global_powerdown)
				zero_cnt_reg[i] <= 11'h000;
			else if (sample_valid) begin
				if (din_word[i] != 24'h000000)
					zero_cnt_reg[i] <= 11'h000;
				else if (zero_cnt_reg[i] != `DMPC_ZERO_RUN)
					zero_cnt_reg[i] <= zero_cnt_reg[i] + 11'h001;
			end
		end
		assign zf[i] = (zero_cnt_reg[i] == `DMPC_ZERO_RUN);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			zero_run_flags <= 3'h0;
		else
			zero_run_flags <= zf;
	end

	//------------------------------------------------------------
	// Mute pin and mute decode
	//------------------------------------------------------------
	// The pin is driven weakly from the first clock after reset; a stronger external driver wins,
	// and mute_pin_in carries the resolved level in both cases.
	logic       pin_out_next;
	logic [2:0] pin_mute;
	logic [2:0] soft_mute_next;

	assign pin_out_next = (zero_flag_select == 2'h0) ? &zero_run_flags
		: |(zero_run_flags & sel_mask(zero_flag_select));
	// The pin floats until our own drive comes on, so its level is ignored until then.
	assign pin_mute = {3{mute_pin_in & mute_pin_oe}} & (pin_decode_disable ? 3'h7
		: sel_mask(zero_flag_select));
	// A low pin gives no pin mute, so automute is off while direct mutes stay.
	assign soft_mute_next = channel_mute_select | {3{global_mute}} | pin_mute;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mute_pin_out <= 1'b0;
			mute_pin_oe  <= 1'b0;
		end else begin
			mute_pin_out <= pin_out_next;
			mute_pin_oe  <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			soft_mute <= 3'h0;
		else
			soft_mute <= soft_mute_next;
	end

	//------------------------------------------------------------
	// Soft mute ramp
	//------------------------------------------------------------
	// A shift-subtract decay gives roughly a 64-sample time constant at no multiplier cost.
	dmpc_pkg::dmpc_gain_type gain_reg [3];

	for (genvar i = 0; i < 3; i++) begin : g_ramp
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn)
				gain_reg[i] <= `DMPC_GAIN_FULL;
			else if (!soft_mute[i])
				gain_reg[i] <= `DMPC_GAIN_FULL;
			else if (sample_valid)
				gain_reg[i] <= decay(gain_reg[i]);
		end
	end

	assign pair1_gain = gain_reg[0];
	assign pair2_gain = gain_reg[1];
	assign pair3_gain = gain_reg[2];

	//------------------------------------------------------------
	// Analogue mute, de-emphasis and powerdown
	//------------------------------------------------------------
	logic powerdown_prev_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			analog_mute       <= 3'h0;
			channel_select_a_en         <= 3'h0;
			pair_powered_down <= 3'h0;
			history_clear     <= 1'b0;
			filter_reinit     <= 1'b0;
			powerdown_prev_reg <= 1'b0;
		end else begin
			analog_mute <= {3{infinite_zero_analog_mute_en & sw_mode}}
				& (zf | channel_mute_select | {3{global_mute}});
			channel_select_a_en <= channel_select_a | {3{global_channel_select_a}};
			pair_powered_down <= pair_disable | {3{global_powerdown}};
			history_clear <= global_powerdown;
			filter_reinit <= powerdown_prev_reg & ~global_powerdown;
			powerdown_prev_reg <= global_powerdown;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	sequence s_powerdown_fall;
		powerdown_prev_reg ##1 !powerdown_prev_reg;
	endsequence

	sequence s_global_write;
		write_strobe && write_addr == `DMPC_ADDR_CHANNEL_CONTROL && shift_reg[0];
	endsequence

	AST_CHMUTE: assert property (@(posedge clk) disable iff (!resetn)
		(mute_channel_select_a_reg[`DMPC_CHMUTE_LSB +: 3] != 3'h0) |=> ((soft_mute & $past(channel_mute_select))
		== $past(channel_mute_select)))
		else $error("Per-pair mute bit did not mute its pair.");

	AST_GLOBAL_MUTE: assert property (@(posedge clk) disable iff (!resetn)
		s_global_write |=> ##1 (soft_mute == 3'h7))
		else $error("Global mute write did not mute all pairs.");

	AST_PIN_ALL: assert property (@(posedge clk) disable iff (!resetn)
		(mute_pin_in && pin_decode_disable) |=> (soft_mute == 3'h7))
		else $error("Decode-disabled high pin did not mute all pairs.");

	AST_PIN_SEL: assert property (@(posedge clk) disable iff (!resetn)
		(mute_pin_in && !pin_decode_disable && zero_flag_select == 2'h2) |=> soft_mute[1])
		else $error("High pin with select two did not mute pair two.");

	AST_NO_AUTOMUTE: assert property (@(posedge clk) disable iff (!resetn)
		!mute_pin_in |=> (soft_mute == ($past(channel_mute_select) | {3{$past(global_mute)}})))
		else $error("Low pin still produced a mute not set by register bits.");

	AST_ZERO_FLAG: assert property (@(posedge clk) disable iff (!resetn)
		(sample_valid && !global_powerdown && din1_sample == 24'h0
		&& zero_cnt_reg[0] == 11'h3FF) |=> zf[0] ##1 zero_run_flags[0])
		else $error("Zero flag not raised after 1024 zero samples.");

	AST_ZERO_RESTART: assert property (@(posedge clk) disable iff (!resetn)
		(sample_valid && din2_sample != 24'h0) |=> (zero_cnt_reg[1] == 11'h000 && !zf[1]))
		else $error("Non-zero sample did not restart the zero counter.");

	AST_PIN_OUT: assert property (@(posedge clk) disable iff (!resetn)
		(zero_flag_select == 2'h0 && $stable(zero_flag_select) && zero_run_flags == 3'h7)
		|=> mute_pin_out)
		else $error("Mute pin not driven high with all zero flags set.");

	AST_ANALOG_HW: assert property (@(posedge clk) disable iff (!resetn)
		mode_pin |=> (analog_mute == 3'h0))
		else $error("Analogue mute active in hardware mode.");

	AST_POWERDOWN: assert property (@(posedge clk) disable iff (!resetn)
		global_powerdown |=> (pair_powered_down == 3'h7 && history_clear))
		else $error("Global powerdown did not power down every pair.");

	AST_CHANNEL_SELECT_A: assert property (@(posedge clk) disable iff (!resetn)
		global_channel_select_a |=> (channel_select_a_en == 3'h7))
		else $error("Global de-emphasis did not reach every pair.");

	AST_PAIR_DISABLE: assert property (@(posedge clk) disable iff (!resetn)
		(pair_disable != 3'h0) |=> ((pair_powered_down & $past(pair_disable)) == $past(pair_disable)))
		else $error("Pair disable bit did not power its pair down.");

	AST_ANALOG_DIRECT: assert property (@(posedge clk) disable iff (!resetn)
		(infinite_zero_analog_mute_en && sw_mode && global_mute) |=> (analog_mute == 3'h7))
		else $error("Direct mute with infinite-zero enabled gave no analogue mute.");

	AST_HISTORY: assert property (@(posedge clk) disable iff (!resetn)
		global_powerdown |=> (zero_cnt_reg[0] == 11'h000 && zero_cnt_reg[1] == 11'h000
		&& zero_cnt_reg[2] == 11'h000))
		else $error("Powerdown did not clear the zero-run history.");

	AST_REINIT: assert property (@(posedge clk) disable iff (!resetn)
		s_powerdown_fall |-> filter_reinit ##1 !filter_reinit)
		else $error("Filter reinitialise pulse missing after powerdown release.");

	AST_RAMP: assert property (@(posedge clk) disable iff (!resetn)
		(soft_mute[0] && sample_valid) |=> (gain_reg[0] == decay($past(gain_reg[0]))))
		else $error("Soft mute ramp step wrong.");

	AST_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
		$fell(soft_mute[2]) |=> (gain_reg[2] == `DMPC_GAIN_FULL))
		else $error("Release did not restore full gain at once.");

endmodule : dmpc_top

// ---- bench/dmpc_host_model.sv ----
// Serial control host and external mute driver facing the mute and powerdown control.
module dmpc_host_model (
	input  wire logic clk,
	input  wire logic mute_pin_out,
	input  wire logic mute_pin_oe,
	output logic      ctrl_latch,
	output logic      ctrl_clk,
	output logic      ctrl_data,
	output logic      mute_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ext_en    = 1'b0;
	logic ext_level = 1'b0;
	// The external driver wins over the weak on-chip drive; an undriven pin is not trusted.
	assign mute_pin_in = ext_en ? ext_level : (mute_pin_oe ? mute_pin_out : ~mute_pin_out);
	initial begin
		ctrl_latch = 1'b0;
		ctrl_clk   = 1'b0;
		ctrl_data  = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	task automatic set_ext(input logic en, input logic lvl);
		ext_en    <= en;
		ext_level <= lvl;
	endtask : set_ext
	// Each level stays three clocks because the block only sees the serial clock by sampling.
	task automatic write_reg(input logic [6:0] addr, input logic [8:0] data);
		logic [15:0] word;
		word = {addr, data};
		ctrl_latch <= 1'b0;
		hold(3);
		for (int i = 15; i >= 0; i--) begin
			ctrl_data <= word[i];
			hold(3);
			ctrl_clk <= 1'b1;
			hold(3);
			ctrl_clk <= 1'b0;
		end
		hold(3);
		ctrl_latch <= 1'b1;
		hold(1);
	endtask : write_reg
endmodule : dmpc_host_model

// ---- bench/dmpc_top_bench.sv ----
// Self-checking bench of the mute and powerdown control.
module dmpc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk          = 1'b0;
	logic        resetn       = 1'b0;
	logic        mode_pin     = 1'b0;
	logic        sample_valid = 1'b0;
	logic [23:0] din1_sample  = 24'h000000;
	logic [23:0] din2_sample  = 24'h000001;
	logic [23:0] din3_sample  = 24'h000001;
	logic        ctrl_latch, ctrl_clk, ctrl_data, mute_pin_in, mute_pin_out, mute_pin_oe;
	logic        history_clear, filter_reinit;
	logic [2:0]  soft_mute, zero_run_flags, analog_mute, channel_select_a_en, pair_powered_down;
	logic [15:0] pair1_gain, pair2_gain, pair3_gain;
	int          errors      = 0;
	int          comparisons = 0;
	int          pulses;
	always #12.5 clk = ~clk;
	dmpc_host_model host (.clk, .mute_pin_out, .mute_pin_oe, .ctrl_latch, .ctrl_clk, .ctrl_data,
		.mute_pin_in);
	dmpc_top DUT (.clk, .resetn, .mode_pin, .ctrl_latch, .ctrl_clk, .ctrl_data, .sample_valid,
		.din1_sample, .din2_sample, .din3_sample, .mute_pin_in, .mute_pin_out, .mute_pin_oe,
		.soft_mute, .pair1_gain, .pair2_gain, .pair3_gain, .zero_run_flags, .analog_mute,
		.channel_select_a_en, .pair_powered_down, .history_clear, .filter_reinit);
	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		host.write_reg(a, d);
		repeat (4) @(posedge clk);
	endtask : wr
	// Samples come every other clock so the ramp sees one step per sample.
	task automatic feed(input int n, input logic [23:0] d1);
		repeat (n) begin
			@(posedge clk);
			din1_sample  <= d1;
			sample_valid <= 1'b1;
			@(posedge clk);
			sample_valid <= 1'b0;
		end
		repeat (6) @(posedge clk);
	endtask : feed
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_masks();
		for (int v = 0; v < 8; v++) begin
			wr(7'h09, 9'(v << 3));
			chk(16'(soft_mute), 16'(v), "pair mute field");
			wr(7'h09, 9'(v << 6));
			chk(16'(channel_select_a_en), 16'(v), "deemphasis field");
		end
	endtask : t_masks
	task automatic t_global();
		wr(7'h02, 9'h013);
		chk(16'(soft_mute), 16'h0007, "global mute");
		chk(16'(channel_select_a_en), 16'h0007, "global deemphasis");
		chk(16'(analog_mute), 16'h0007, "analogue mute on direct mute");
		mode_pin <= 1'b1;
		wr(7'h02, 9'h000);
		chk(16'(analog_mute), 16'h0000, "analogue mute in hardware mode");
		chk(16'(soft_mute), 16'h0007, "write refused in hardware mode");
		mode_pin <= 1'b0;
		wr(7'h02, 9'h000);
		chk(16'(soft_mute), 16'h0000, "global mute cleared");
	endtask : t_global
	task automatic t_pin();
		host.set_ext(1'b1, 1'b1);
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 4; s++) begin
				wr(7'h0C, 9'((m << 6) | s));
				chk(16'(soft_mute), (m == 1 || s == 0) ? 16'h0007 : 16'(1 << (s - 1)),
					"pin decode");
			end
		end
		host.set_ext(1'b0, 1'b0);
	endtask : t_pin
	task automatic t_zero();
		wr(7'h0C, 9'h001);
		wr(7'h02, 9'h010);
		feed(1023, 24'h000000);
		chk(16'(zero_run_flags), 16'h0000, "flag before full run");
		feed(1, 24'h000000);
		chk(16'(zero_run_flags), 16'h0001, "flag after full run");
		chk(16'(mute_pin_out), 16'h0001, "pin shows flag");
		chk(16'(soft_mute), 16'h0001, "own pin mutes");
		chk(16'(analog_mute), 16'h0001, "analogue mute on zero run");
		feed(1, 24'h000000);
		chk(pair1_gain, 16'hFC00, "ramp step");
		chk(pair2_gain, 16'hFFFF, "unmuted pair gain");
		host.set_ext(1'b1, 1'b0);
		feed(1, 24'h000000);
		chk(16'(soft_mute), 16'h0000, "low pin blocks automute");
		chk(pair1_gain, 16'hFFFF, "release restores gain");
		wr(7'h09, 9'h020);
		chk(16'(soft_mute), 16'h0004, "direct mute with pin low");
		host.set_ext(1'b0, 1'b0);
		wr(7'h09, 9'h000);
		feed(1, 24'h000100);
		chk(16'(zero_run_flags), 16'h0000, "non-zero clears flag");
		chk(16'(soft_mute), 16'h0000, "pin released");
		wr(7'h02, 9'h000);
	endtask : t_zero
	task automatic t_all_zero();
		din2_sample <= 24'h000000;
		din3_sample <= 24'h000000;
		wr(7'h0C, 9'h000);
		feed(1024, 24'h000000);
		chk(16'(zero_run_flags), 16'h0007, "all flags after full run");
		chk(16'(mute_pin_out), 16'h0001, "pin shows all flags");
		chk(16'(soft_mute), 16'h0007, "own pin mutes every pair");
		din2_sample <= 24'h000001;
		din3_sample <= 24'h000001;
		feed(1, 24'h000001);
		chk(16'(zero_run_flags), 16'h0000, "non-zero clears all flags");
		chk(16'(soft_mute), 16'h0000, "pin released after run");
	endtask : t_all_zero
	task automatic t_powerdown();
		wr(7'h0A, 9'h00A);
		chk(16'(pair_powered_down), 16'h0005, "pair disable");
		wr(7'h09, 9'h040);
		wr(7'h02, 9'h004);
		chk(16'(pair_powered_down), 16'h0007, "global powerdown");
		chk(16'(history_clear), 16'h0001, "history cleared");
		host.write_reg(7'h02, 9'h000);
		pulses = 0;
		repeat (8) begin
			@(posedge clk);
			pulses += int'(filter_reinit === 1'b1);
		end
		chk(16'(pulses), 16'h0001, "filter reinit pulse");
		chk(16'(pair_powered_down), 16'h0005, "disables kept");
		chk(16'(channel_select_a_en), 16'h0001, "settings kept");
	endtask : t_powerdown
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		chk(pair1_gain, 16'hFFFF, "reset gain");
		chk(16'({mute_pin_oe, soft_mute}), 16'h0008, "reset outputs");
		t_masks();
		t_global();
		t_pin();
		t_zero();
		t_all_zero();
		t_powerdown();
		results();
	end
	// Whole run is under ten thousand clocks; three times that means a hang.
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		$display("BAD %0t watchdog expired", $time);
		results();
	end
endmodule : dmpc_top_bench
